// *** hdl/sowt_pkg.sv ***
// Shared constants, command codes and register map of the ODT and write-leveling timing pair
package sowt_pkg;

  // --------------------------------------------------------------
  // Clock and timing figures
  // --------------------------------------------------------------
  localparam int CLK_PS        = 25000;
  localparam int DODT_SUB      = 2;
  localparam int WR_START_STD  = 4;
  localparam int WR_START_BC4F = 2;
  localparam int ODTH8_PRE1    = 6;
  localparam int ODTH8_PRE2    = 7;
  localparam int ODTH4_PRE1    = 4;
  localparam int ODTH4_PRE2    = 5;
  localparam int WLMRD_CK      = 40;
  localparam int WLDQSEN_CK    = 25;
  localparam int WLO_PS        = 9500;
  localparam int WLOE_PS       = 2000;
  localparam int WLO_CYC       = (WLO_PS / CLK_PS) < 1 ? 1 : (WLO_PS / CLK_PS);
  localparam int WLOE_CYC      = (WLOE_PS / CLK_PS) < 1 ? 1 : (WLOE_PS / CLK_PS);
  localparam int FB_SLACK      = 6;
  localparam int CAL_MIN_CK    = 3;
  localparam int CAL_MIN_PS    = 3748;
  localparam int RD_PRE_EARLY  = 1;
  localparam int BURST_CK      = 4;
  localparam int PS_PER_NS     = 1000;

  // --------------------------------------------------------------
  // Link commands
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP, CMD_WR_BL8, CMD_WR_BC4, CMD_RD, CMD_REF, CMD_WL_ON, CMD_WL_OFF, CMD_ODT
  } sowt_cmd_t;

  // --------------------------------------------------------------
  // Register map (Avalon word addresses) and fields
  // --------------------------------------------------------------
  localparam logic [1:0]  ADDR_CFG    = 2'h0;
  localparam logic [1:0]  ADDR_CMD    = 2'h1;
  localparam logic [1:0]  ADDR_STATUS = 2'h2;
  localparam logic [1:0]  ADDR_TIMING = 2'h3;
  localparam int CFG_CWL_LSB = 0;
  localparam int CFG_AL_LSB  = 5;
  localparam int CFG_PL_LSB  = 10;
  localparam int CFG_CL_LSB  = 14;
  localparam int CFG_BC4F    = 19;
  localparam int CFG_WPRE2   = 20;
  localparam int CFG_RPRE2   = 21;
  localparam int CFG_CAPAR   = 22;
  localparam int CFG_DLLOFF  = 23;
  localparam int CFG_GEAR    = 24;
  localparam int TIM_RFC_LSB = 0;
  localparam int TIM_CCD_LSB = 16;
  localparam int ST_BUSY     = 0;
  localparam int ST_FB       = 1;
  localparam int ST_GEARREF  = 2;
  localparam int ST_CAL_LSB  = 8;
  localparam int ST_RFC_LSB  = 16;
  localparam logic [31:0] CFG_RST = 32'h0002C009;
  localparam logic [31:0] TIM_RST = 32'h0005015E;

  // Cycles from picoseconds, rounded up
  function automatic int ru_cyc(input int ps, input int tck_ps);
    ru_cyc = (ps + tck_ps - 1) / tck_ps;
  endfunction : ru_cyc

endpackage : sowt_pkg

// *** hdl/sowt_link_if.sv ***
// Link between the memory controller end and the DRAM end
`timescale 1ns/100ps
interface sowt_link_if;
  logic       ck;
  logic       cmd_valid;
  logic [2:0] cmd;
  logic       odt;
  logic       dqs_oe_n;
  logic       dqs;
  logic       dq_fb;

  modport ctrl (output ck, output cmd_valid, output cmd, output odt, output dqs_oe_n,
                output dqs, input dq_fb);
  modport dram (input ck, input cmd_valid, input cmd, input odt, input dqs_oe_n,
                input dqs, output dq_fb);
endinterface : sowt_link_if

// *** hdl/sowt_dram.sv ***
// DRAM end: termination latency, internal write start, leveling feedback, read strobe
`timescale 1ns/100ps
module sowt_dram #(
  parameter int HIST_DEPTH = 96
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  sowt_link_if.dram       link,
  input  wire logic [4:0] cfg_cwl_i,
  input  wire logic [4:0] cfg_al_i,
  input  wire logic [3:0] cfg_pl_i,
  input  wire logic [4:0] cfg_cl_i,
  input  wire logic       cfg_bc4_fixed_i,
  input  wire logic       cfg_rpre2_i,
  output logic            rtt_on_o,
  output logic            wr_start_o,
  output logic            dqs_lz_o,
  output logic            wl_mode_o
);

  // --------------------------------------------------------------
  // Link input synchronisers
  // --------------------------------------------------------------
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic       ck_d_reg;
  logic       dqs_d_reg;
  logic [2:0] cmd_s;
  logic       ck_s, cv_s, odt_s, oe_n_s, dqs_s, ck_rise;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      ck_d_reg  <= 1'b0;
      dqs_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {link.ck, link.cmd_valid, link.cmd, link.odt, link.dqs_oe_n, link.dqs};
      sync2_reg <= sync1_reg;
      ck_d_reg  <= ck_s;
      dqs_d_reg <= dqs_s;
    end
  end

  assign {ck_s, cv_s, cmd_s, odt_s, oe_n_s, dqs_s} = sync2_reg;
  assign ck_rise = ck_s & ~ck_d_reg;

  // --------------------------------------------------------------
  // Latency helpers
  // --------------------------------------------------------------
  function automatic logic [6:0] wl_of(input logic [4:0] c, input logic [4:0] a,
                                       input logic [3:0] p);
    wl_of = 7'(c) + 7'(a) + 7'(p);
  endfunction : wl_of

  function automatic logic pick(input logic [HIST_DEPTH-1:0] h, input logic [6:0] idx);
    pick = (int'(idx) < HIST_DEPTH) ? h[idx] : 1'b0;
  endfunction : pick

  logic [6:0] wl, rl, dodt, wr_off, rd_off;
  assign wl     = wl_of(cfg_cwl_i, cfg_al_i, cfg_pl_i);
  assign rl     = wl_of(cfg_cl_i, cfg_al_i, cfg_pl_i);
  assign dodt   = (wl > 7'(sowt_pkg::DODT_SUB)) ? wl - 7'(sowt_pkg::DODT_SUB) : 7'h00;
  assign wr_off = wl + (cfg_bc4_fixed_i ? 7'(sowt_pkg::WR_START_BC4F)
                                        : 7'(sowt_pkg::WR_START_STD));
  assign rd_off = (rl > 7'(1 + sowt_pkg::RD_PRE_EARLY))
                ? rl - 7'(sowt_pkg::RD_PRE_EARLY) - (cfg_rpre2_i ? 7'h01 : 7'h00) : 7'h00;

  // --------------------------------------------------------------
  // Per-CK histories of ODT, writes and reads
  // --------------------------------------------------------------
  logic [HIST_DEPTH-1:0] odt_hist_reg, wr_hist_reg, rd_hist_reg;
  logic [HIST_DEPTH-1:0] odt_hist_next, wr_hist_next, rd_hist_next;
  logic                  is_wr, is_rd;

  assign is_wr = cv_s & ((cmd_s == 3'(sowt_pkg::CMD_WR_BL8))
                       | (cmd_s == 3'(sowt_pkg::CMD_WR_BC4)));
  assign is_rd = cv_s & (cmd_s == 3'(sowt_pkg::CMD_RD));
  assign odt_hist_next = {odt_hist_reg[HIST_DEPTH-2:0], odt_s};
  assign wr_hist_next  = {wr_hist_reg[HIST_DEPTH-2:0], is_wr};
  assign rd_hist_next  = {rd_hist_reg[HIST_DEPTH-2:0], is_rd};

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      odt_hist_reg <= '0;
      wr_hist_reg  <= '0;
      rd_hist_reg  <= '0;
    end else if (ck_rise) begin
      odt_hist_reg <= odt_hist_next;
      wr_hist_reg  <= wr_hist_next;
      rd_hist_reg  <= rd_hist_next;
    end
  end

  // --------------------------------------------------------------
  // Termination follows ODT after the same latency both ways
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rtt_on_o <= 1'b0;
    end else if (ck_rise) begin
      rtt_on_o <= pick(odt_hist_next, dodt);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_start_o <= 1'b0;
    end else begin
      wr_start_o <= ck_rise & pick(wr_hist_next, wr_off);
    end
  end

  // --------------------------------------------------------------
  // Read strobe drive window
  // --------------------------------------------------------------
  logic [3:0] lz_cnt_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lz_cnt_reg <= 4'h0;
      dqs_lz_o   <= 1'b0;
    end else if (ck_rise) begin
      if (pick(rd_hist_next, rd_off)) begin
        lz_cnt_reg <= 4'(sowt_pkg::BURST_CK) + (cfg_rpre2_i ? 4'h2 : 4'h1);
        dqs_lz_o   <= 1'b1;
      end else if (lz_cnt_reg > 4'h1) begin
        lz_cnt_reg <= lz_cnt_reg - 4'h1;
      end else begin
        lz_cnt_reg <= 4'h0;
        dqs_lz_o   <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Write leveling: sample CK on strobe rise
  // --------------------------------------------------------------
  logic fb_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wl_mode_o <= 1'b0;
      fb_reg    <= 1'b0;
    end else begin
      if (ck_rise & cv_s & (cmd_s == 3'(sowt_pkg::CMD_WL_ON))) begin
        wl_mode_o <= 1'b1;
      end else if (ck_rise & cv_s & (cmd_s == 3'(sowt_pkg::CMD_WL_OFF))) begin
        wl_mode_o <= 1'b0;
      end
      if (wl_mode_o & ~oe_n_s & dqs_s & ~dqs_d_reg) begin
        fb_reg <= ck_s;
      end else if (!wl_mode_o) begin
        fb_reg <= 1'b0;
      end
    end
  end

  assign link.dq_fb = fb_reg;

endmodule : sowt_dram

// *** hdl/sowt_ctrl.sv ***
// Controller end: Avalon-MM registers, CK divider and command sequencing
`timescale 1ns/100ps
module sowt_ctrl #(
  parameter int CK_HALF = 4
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  sowt_link_if.ctrl        link,
  input  wire logic [1:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  localparam int TCK_PS  = 2 * CK_HALF * sowt_pkg::CLK_PS;
  // Feedback wait in system cycles: both synchronisers plus output delay and error
  localparam int FB_WAIT = sowt_pkg::FB_SLACK + sowt_pkg::WLO_CYC + sowt_pkg::WLOE_CYC;

  typedef enum {ST_IDLE, ST_ISSUE, ST_ODT, ST_WAIT, ST_WL_EN, ST_WL_FB, ST_WL_EXIT} sowt_state_t;

  // --------------------------------------------------------------
  // CK divider, link changes on falling CK except the write-leveling strobe fall
  // --------------------------------------------------------------
  logic [7:0] div_cnt_reg;
  logic       ck_reg;
  logic       tick;

  assign tick = (div_cnt_reg == 8'(CK_HALF - 1)) & ck_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= 8'h00;
      ck_reg      <= 1'b0;
    end else if (div_cnt_reg == 8'(CK_HALF - 1)) begin
      div_cnt_reg <= 8'h00;
      ck_reg      <= ~ck_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // Feedback synchroniser
  // --------------------------------------------------------------
  logic fb_s1_reg, fb_s2_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_s1_reg <= 1'b0;
      fb_s2_reg <= 1'b0;
    end else begin
      fb_s1_reg <= link.dq_fb;
      fb_s2_reg <= fb_s1_reg;
    end
  end

  // --------------------------------------------------------------
  // Register fields and derived cycle counts
  // --------------------------------------------------------------
  logic [31:0] cfg_reg, tim_reg;
  logic [4:0]  cwl, al, cl;
  logic [3:0]  pl, ccdl, cal;
  logic [9:0]  rfc_ck;
  logic [2:0]  odth8, odth4;

  assign cwl  = cfg_reg[sowt_pkg::CFG_CWL_LSB +: 5];
  assign al   = cfg_reg[sowt_pkg::CFG_AL_LSB +: 5];
  assign pl   = cfg_reg[sowt_pkg::CFG_PL_LSB +: 4];
  assign cl   = cfg_reg[sowt_pkg::CFG_CL_LSB +: 5];
  assign ccdl = tim_reg[sowt_pkg::TIM_CCD_LSB +: 4];
  assign rfc_ck = 10'(sowt_pkg::ru_cyc(int'(tim_reg[sowt_pkg::TIM_RFC_LSB +: 12])
                                       * sowt_pkg::PS_PER_NS, TCK_PS))
                + ((cfg_reg[sowt_pkg::CFG_CAPAR] & cfg_reg[sowt_pkg::CFG_DLLOFF])
                   ? 10'(pl) : 10'h000);
  assign cal = (sowt_pkg::ru_cyc(sowt_pkg::CAL_MIN_PS, TCK_PS) > sowt_pkg::CAL_MIN_CK)
             ? 4'(sowt_pkg::ru_cyc(sowt_pkg::CAL_MIN_PS, TCK_PS)) : 4'(sowt_pkg::CAL_MIN_CK);
  assign odth8 = cfg_reg[sowt_pkg::CFG_WPRE2] ? 3'(sowt_pkg::ODTH8_PRE2)
                                              : 3'(sowt_pkg::ODTH8_PRE1);
  assign odth4 = cfg_reg[sowt_pkg::CFG_WPRE2] ? 3'(sowt_pkg::ODTH4_PRE2)
                                              : 3'(sowt_pkg::ODTH4_PRE1);

  // --------------------------------------------------------------
  // Avalon-MM slave
  // --------------------------------------------------------------
  sowt_state_t state_reg;
  logic        wait_reg, acc, commit, gear_ref_reg, fb_reg;
  logic [31:0] rd_mux;

  // Command writes stall while a sequence runs, so software cannot overrun it
  assign acc    = (avs_read_i | avs_write_i) & wait_reg
                & ~(avs_write_i & (avs_address_i == sowt_pkg::ADDR_CMD) & (state_reg != ST_IDLE));
  assign commit = avs_write_i & ~wait_reg;

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      sowt_pkg::ADDR_CFG:    rd_mux = cfg_reg;
      sowt_pkg::ADDR_TIMING: rd_mux = tim_reg;
      sowt_pkg::ADDR_STATUS: begin
        rd_mux[sowt_pkg::ST_BUSY]          = (state_reg != ST_IDLE);
        rd_mux[sowt_pkg::ST_FB]            = fb_reg;
        rd_mux[sowt_pkg::ST_GEARREF]       = gear_ref_reg;
        rd_mux[sowt_pkg::ST_CAL_LSB +: 4]  = cal;
        rd_mux[sowt_pkg::ST_RFC_LSB +: 10] = rfc_ck;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg       <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      wait_reg <= ~acc;
      if (acc) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end
  assign avs_waitrequest_o = wait_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg      <= sowt_pkg::CFG_RST;
      tim_reg      <= sowt_pkg::TIM_RST;
      gear_ref_reg <= 1'b0;
    end else if (commit) begin
      if (avs_address_i == sowt_pkg::ADDR_CFG) begin
        cfg_reg <= avs_writedata_i;
        cfg_reg[sowt_pkg::CFG_GEAR] <= 1'b0;
        if (avs_writedata_i[sowt_pkg::CFG_GEAR]) begin
          gear_ref_reg <= 1'b1;
        end
      end else if (avs_address_i == sowt_pkg::ADDR_TIMING) begin
        tim_reg <= avs_writedata_i;
      end else if (avs_address_i == sowt_pkg::ADDR_STATUS &&
                   avs_writedata_i[sowt_pkg::ST_GEARREF]) begin
        gear_ref_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------
  logic [2:0]  op_reg, cmd_reg;
  logic [9:0]  cnt_reg;
  logic [7:0]  fbw_reg;
  logic        cv_reg, odt_reg, oe_n_reg, dqs_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      op_reg    <= 3'h0;
      cmd_reg   <= 3'h0;
      cnt_reg   <= 10'h000;
      fbw_reg   <= 8'h00;
      cv_reg    <= 1'b0;
      odt_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
      dqs_reg   <= 1'b0;
      fb_reg    <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (commit && avs_address_i == sowt_pkg::ADDR_CMD) begin
            op_reg    <= avs_writedata_i[2:0];
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE: if (tick) begin
          cmd_reg <= op_reg;
          cv_reg  <= (op_reg != 3'(sowt_pkg::CMD_ODT)) & (op_reg != 3'(sowt_pkg::CMD_NOP))
                   & (op_reg != 3'(sowt_pkg::CMD_WL_OFF));
          case (op_reg)
            3'(sowt_pkg::CMD_WR_BL8): begin
              odt_reg   <= 1'b1;
              cnt_reg   <= 10'(odth8 - 3'h1);
              state_reg <= ST_ODT;
            end
            3'(sowt_pkg::CMD_WR_BC4), 3'(sowt_pkg::CMD_ODT): begin
              odt_reg   <= 1'b1;
              cnt_reg   <= 10'(odth4 - 3'h1);
              state_reg <= ST_ODT;
            end
            3'(sowt_pkg::CMD_WL_ON): begin
              cnt_reg   <= 10'h000;
              state_reg <= ST_WL_EN;
            end
            3'(sowt_pkg::CMD_REF): begin
              cnt_reg   <= rfc_ck;
              state_reg <= ST_WAIT;
            end
            3'(sowt_pkg::CMD_RD): begin
              cnt_reg   <= 10'(cl) + 10'(al) + 10'(pl) + 10'(sowt_pkg::BURST_CK);
              state_reg <= ST_WAIT;
            end
            default: state_reg <= ST_IDLE;
          endcase
        end
        ST_ODT: if (tick) begin
          cv_reg <= 1'b0;
          if (cnt_reg == 10'h000) begin
            odt_reg   <= 1'b0;
            cnt_reg   <= 10'(ccdl);
            state_reg <= ST_WAIT;
          end else begin
            cnt_reg <= cnt_reg - 10'h001;
          end
        end
        ST_WAIT: if (tick) begin
          cv_reg <= 1'b0;
          if (cnt_reg == 10'h000) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 10'h001;
          end
        end
        ST_WL_EN: if (tick) begin
          cv_reg  <= 1'b0;
          cnt_reg <= cnt_reg + 10'h001;
          if (cnt_reg + 10'h001 == 10'(sowt_pkg::WLDQSEN_CK)) begin
            oe_n_reg <= 1'b0;
          end
          if (cnt_reg + 10'h001 == 10'(sowt_pkg::WLMRD_CK)) begin
            dqs_reg   <= 1'b1;
            fbw_reg   <= 8'(FB_WAIT);
            state_reg <= ST_WL_FB;
          end
        end
        ST_WL_FB: begin
          if (fbw_reg == 8'h00) begin
            fb_reg    <= fb_s2_reg;
            dqs_reg   <= 1'b0;
            state_reg <= ST_WL_EXIT;
          end else begin
            fbw_reg <= fbw_reg - 8'h01;
          end
        end
        ST_WL_EXIT: if (tick) begin
          oe_n_reg  <= 1'b1;
          cmd_reg   <= 3'(sowt_pkg::CMD_WL_OFF);
          cv_reg    <= 1'b1;
          cnt_reg   <= 10'(ccdl);
          state_reg <= ST_WAIT;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign link.ck        = ck_reg;
  assign link.cmd_valid = cv_reg;
  assign link.cmd       = cmd_reg;
  assign link.odt       = odt_reg;
  assign link.dqs_oe_n  = oe_n_reg;
  assign link.dqs       = dqs_reg;

endmodule : sowt_ctrl

// *** tb/sowt_properties.sv ***
// Link checker for the controller and DRAM ends
`timescale 1ns/100ps
module sowt_properties #(
  parameter int CK_HALF = 4
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       ck,
  input wire logic       cmd_valid,
  input wire logic [2:0] cmd,
  input wire logic       odt,
  input wire logic       dqs_oe_n,
  input wire logic       dqs,
  input wire logic       dq_fb
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       ck_q;
  logic       bl8_reg;
  logic [7:0] half_reg;
  logic [7:0] cv_reg;
  logic [7:0] hi_reg;
  logic [7:0] wl_reg;
  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  // Ck edges found by sampling, as the DRAM end does
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ck_q     <= 1'b0;
      bl8_reg  <= 1'b0;
      half_reg <= 8'hFF;
      cv_reg   <= 8'h00;
      hi_reg   <= 8'h00;
      wl_reg   <= 8'hFF;
    end else begin
      ck_q     <= ck;
      cv_reg   <= cmd_valid ? cv_reg + 8'h01 : 8'h00;
      hi_reg   <= !odt ? 8'h00 : hi_reg + {7'h00, ck & ~ck_q};
      if (cmd_valid) begin
        bl8_reg <= (cmd == sowt_pkg::CMD_WR_BL8);
      end else if (!odt) begin
        bl8_reg <= 1'b0;
      end
      // Saturating, so the first half period after reset is not judged
      if (ck != ck_q) begin
        half_reg <= 8'h00;
      end else if (half_reg != 8'hFF) begin
        half_reg <= half_reg + 8'h01;
      end
      if (cmd_valid && cmd == sowt_pkg::CMD_WL_ON) begin
        wl_reg <= 8'h00;
      end else if (!ck && ck_q && wl_reg != 8'hFF) begin
        wl_reg <= wl_reg + 8'h01;
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_ck_half;
    (ck != ck_q) && (half_reg != 8'hFF) |-> half_reg >= 8'(CK_HALF - 1);
  endproperty
  a_ck_half: assert property (p_ck_half) else $error("link clock half period too short");
  property p_cmd_fall;
    $rose(cmd_valid) |-> $fell(ck);
  endproperty
  a_cmd_fall: assert property (p_cmd_fall) else $error("command not launched at ck fall");
  property p_cmd_len;
    $fell(cmd_valid) |-> cv_reg == 8'(2 * CK_HALF) && $fell(ck);
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("command not one ck period");
  property p_odt_cmd;
    $rose(odt) |-> cmd_valid ? (cmd == sowt_pkg::CMD_WR_BL8 || cmd == sowt_pkg::CMD_WR_BC4)
                             : (cmd == sowt_pkg::CMD_ODT);
  endproperty
  a_odt_cmd: assert property (p_odt_cmd) else $error("odt raised without command");
  property p_odt_min4;
    $fell(odt) |-> hi_reg >= 8'(sowt_pkg::ODTH4_PRE1);
  endproperty
  a_odt_min4: assert property (p_odt_min4) else $error("odt high too short");
  property p_odt_bl8;
    $fell(odt) && bl8_reg |-> hi_reg >= 8'(sowt_pkg::ODTH8_PRE1);
  endproperty
  a_odt_bl8: assert property (p_odt_bl8) else $error("odt too short for bl8 write");
  property p_dqs_en;
    $fell(dqs_oe_n) |-> wl_reg >= 8'(sowt_pkg::WLDQSEN_CK - 1);
  endproperty
  a_dqs_en: assert property (p_dqs_en) else $error("strobe enabled too early");
  property p_dqs_rise;
    $rose(dqs) |-> !dqs_oe_n && wl_reg >= 8'(sowt_pkg::WLMRD_CK - 1);
  endproperty
  a_dqs_rise: assert property (p_dqs_rise) else $error("strobe rise too early");
  property p_fb_wait;
    $rose(dqs) |-> dqs[*8];
  endproperty
  a_fb_wait: assert property (p_fb_wait) else $error("feedback wait cut short");
  c_wl: cover property ($rose(dqs) ##[8:12] $fell(dqs));
  c_bl8: cover property ($fell(odt) && bl8_reg);
  c_rd: cover property (cmd_valid && cmd == sowt_pkg::CMD_RD);
endmodule : sowt_properties

// *** tb/sdram_odt_wrlvl_timing_tb.sv ***
// Bench joining the controller and DRAM ends over the link
`timescale 1ns/100ps
module sdram_odt_wrlvl_timing_tb;
  logic        sys_clk_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [1:0]  adr         = 2'h0;
  logic        rd          = 1'b0;
  logic        wr          = 1'b0;
  logic [31:0] wdat        = 32'h0;
  logic [4:0]  cwl         = 5'h09;
  logic [4:0]  al          = 5'h00;
  logic [3:0]  pl          = 4'h0;
  logic [4:0]  cl          = 5'h0B;
  logic        bc4f        = 1'b0;
  logic        rp2         = 1'b0;
  logic        wlm_seen    = 1'b0;
  logic        wait_o, rtt, wrs, lz, wlm, ck_q, odt_q, rtt_q, lz_q, cv_q;
  logic [7:0]  on_n, off_n, cmd_n, on_lat, off_lat, wr_lat, lz_lat;
  logic [31:0] rdat, q;
  int          wl, rl;
  int          mismatches  = 0;
  int          checks_done = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sowt_link_if link ();
  sowt_ctrl #(.CK_HALF(4)) sowt_ctrl_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link(link),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o));
  sowt_dram #(.HIST_DEPTH(96)) sowt_dram_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .link(link), .cfg_cwl_i(cwl), .cfg_al_i(al), .cfg_pl_i(pl), .cfg_cl_i(cl),
    .cfg_bc4_fixed_i(bc4f), .cfg_rpre2_i(rp2), .rtt_on_o(rtt), .wr_start_o(wrs),
    .dqs_lz_o(lz), .wl_mode_o(wlm));
  sowt_properties #(.CK_HALF(4)) sowt_properties_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .ck(link.ck), .cmd_valid(link.cmd_valid), .cmd(link.cmd), .odt(link.odt),
    .dqs_oe_n(link.dqs_oe_n), .dqs(link.dqs), .dq_fb(link.dq_fb));
  // ------------------------------------------------------------
  // Latency monitor, in ck rises counted from each cause
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    ck_q <= link.ck;
    odt_q <= link.odt;
    rtt_q <= rtt;
    lz_q <= lz;
    cv_q <= link.cmd_valid;
    if (link.ck && !ck_q) begin
      on_n <= on_n + 8'h01;
      off_n <= off_n + 8'h01;
      cmd_n <= cmd_n + 8'h01;
    end
    // Start at FF so the registering rise reads 0; stale results cleared
    if (link.odt && !odt_q) begin
      on_n <= 8'hFF;
      on_lat <= 8'hFF;
    end
    if (!link.odt && odt_q) begin
      off_n <= 8'hFF;
      off_lat <= 8'hFF;
    end
    if (link.cmd_valid && !cv_q) begin
      cmd_n <= 8'hFF;
      wr_lat <= 8'hFF;
      lz_lat <= 8'hFF;
    end
    if (rtt && !rtt_q) on_lat <= on_n;
    if (!rtt && rtt_q) off_lat <= off_n;
    if (lz && !lz_q) lz_lat <= cmd_n;
    if (wrs === 1'b1) wr_lat <= cmd_n;
    if (wlm === 1'b1) wlm_seen <= 1'b1;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk_i);
    while (wait_o !== 1'b0) @(posedge sys_clk_i);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk_i);
  endtask : acc
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Long settle so late latencies land before checking
  task automatic run(input logic [2:0] op);
    acc(1'b1, sowt_pkg::ADDR_CMD, {29'h0, op});
    q = 32'h1;
    while (q[sowt_pkg::ST_BUSY] !== 1'b0) acc(1'b0, sowt_pkg::ADDR_STATUS, 32'h0);
    repeat (160) @(posedge sys_clk_i);
  endtask : run
  task automatic setcfg(input logic [4:0] w, a, input logic [3:0] p, input logic b, c);
    cwl <= w;
    al <= a;
    pl <= p;
    bc4f <= b;
    rp2 <= b;
    acc(1'b1, sowt_pkg::ADDR_CFG, {8'h00, c, c, b, b, b, cl, p, a, w});
  endtask : setcfg
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    acc(1'b0, sowt_pkg::ADDR_CFG, 32'h0);
    chk("cfg_reset", q, sowt_pkg::CFG_RST);
    acc(1'b0, sowt_pkg::ADDR_TIMING, 32'h0);
    chk("timing_reset", q, sowt_pkg::TIM_RST);
    acc(1'b0, sowt_pkg::ADDR_STATUS, 32'h0);
    chk("cal_min", {28'h0, q[11:8]}, 32'h3);
    acc(1'b1, sowt_pkg::ADDR_TIMING, 32'h00050001);
    acc(1'b0, sowt_pkg::ADDR_STATUS, 32'h0);
    chk("rfc_round", {22'h0, q[25:16]}, 32'h1);
    setcfg(5'h09, 5'h00, 4'h2, 1'b0, 1'b1);
    acc(1'b0, sowt_pkg::ADDR_STATUS, 32'h0);
    chk("rfc_parity", {22'h0, q[25:16]}, 32'h3);
    acc(1'b1, sowt_pkg::ADDR_CFG, 32'h0102C009);
    acc(1'b0, sowt_pkg::ADDR_CFG, 32'h0);
    chk("gear_cfg", q, 32'h0002C009);
    acc(1'b0, sowt_pkg::ADDR_STATUS, 32'h0);
    chk("gear_flag", {31'h0, q[2]}, 32'h1);
    acc(1'b1, sowt_pkg::ADDR_STATUS, 32'h4);
    acc(1'b0, sowt_pkg::ADDR_STATUS, 32'h0);
    chk("gear_clear", {31'h0, q[2]}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      setcfg(5'(9 + i), 5'(i), 4'(2 * i), i[0], 1'b0);
      wl = cwl + al + pl;
      rl = cl + al + pl;
      run(sowt_pkg::CMD_WR_BL8);
      chk("rtt_on_lat", 32'(on_lat), 32'(wl - 2));
      chk("rtt_off_lat", 32'(off_lat), 32'(wl - 2));
      chk("wr_start_bl8", 32'(wr_lat), 32'(wl + (bc4f ? 2 : 4)));
      run(sowt_pkg::CMD_WR_BC4);
      chk("wr_start_bc4", 32'(wr_lat), 32'(wl + (bc4f ? 2 : 4)));
      run(sowt_pkg::CMD_RD);
      chk("dqs_lz_lat", 32'(lz_lat), 32'(rl - (rp2 ? 2 : 1)));
    end
    run(sowt_pkg::CMD_REF);
    run(sowt_pkg::CMD_ODT);
    run(sowt_pkg::CMD_WL_ON);
    chk("wl_mode", {31'h0, wlm_seen}, 32'h1);
    chk("wl_feedback", {31'h0, q[sowt_pkg::ST_FB]}, 32'h0);
    finish_test();
  end
endmodule : sdram_odt_wrlvl_timing_tb
